/* porst_partner.sv */
// Partner model: the analog supply detectors and the crystal on the oscillator input pin.
// Assumes the bench drives vdd_mv and osc_run just after the rising edge of clk.
`timescale 1ns/100ps
module porst_partner #(
    parameter int POR_LEVEL_MV = 1500,
    parameter int BROWN_OUT_MV = 4000,
    parameter int HALF_CYCLES  = 4
) (
    input  wire logic        clk,
    input  wire logic [15:0] vdd_mv,
    input  wire logic        osc_run,
    output logic             supply_ok,
    output logic             below_brown_out_threshold,
    output logic             oscillator_input_pin,
    output int               pin_edges
);
    int half_cnt;

    initial begin
        supply_ok = 1'b0;
        below_brown_out_threshold = 1'b1;
        oscillator_input_pin = 1'b0;
        pin_edges = 0;
        half_cnt = 0;
    end

    // Detectors are sampled on clk so the sequencer sees them synchronous, as it expects.
    always @(posedge clk) begin
        supply_ok <= (int'(vdd_mv) >= POR_LEVEL_MV);
        below_brown_out_threshold <= (int'(vdd_mv) < BROWN_OUT_MV);
        if (!osc_run) begin
            // A stopped crystal leaves the pin still, so no stray edges reach the count.
            oscillator_input_pin <= 1'b0;
            half_cnt <= 0;
            pin_edges <= 0;
        end else if (half_cnt == HALF_CYCLES - 1) begin
            half_cnt <= 0;
            oscillator_input_pin <= !oscillator_input_pin;
            if (!oscillator_input_pin) begin
                pin_edges <= pin_edges + 1;
            end
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end
endmodule

/* porst_pkg.sv */
// Package for the power-on reset sequencer: timing constants, modes and states.
// Assumes a single 250 MHz system clock domain.
package porst_pkg;
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Power-up timer hold, nominal, in milliseconds.
    localparam int unsigned PWRUP_HOLD_MS = 72;

    // Brown-out minimum duration in microseconds, and its cycle count at the system clock.
    localparam int unsigned BROWN_OUT_MIN_DURATION_US = 100;
    localparam int unsigned BROWN_OUT_MIN_CYCLES =
        (BROWN_OUT_MIN_DURATION_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned BROWN_OUT_CNT_W = 16;

    // Internal RC oscillator tick period in microseconds; the hold is counted in these ticks.
    localparam int unsigned RC_TICK_US = 1;
    localparam int unsigned RC_TICK_CYCLES = (RC_TICK_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned RC_DIV_W = 8;
    localparam int unsigned PWRUP_HOLD_TICKS = (PWRUP_HOLD_MS * 1000) / RC_TICK_US;
    localparam int unsigned PWRUP_CNT_W = 17;

    // Oscillator start-up count, in cycles of the oscillator input pin.
    localparam int unsigned OSC_STARTUP_CYCLES = 1024;
    localparam int unsigned OSC_CNT_W = 11;

    // Oscillator mode selection, as held in the configuration word.
    localparam logic [1:0] OSC_MODE_LOW_POWER_CRYSTAL  = 2'h0;
    localparam logic [1:0] OSC_MODE_MEDIUM_CRYSTAL     = 2'h1;
    localparam logic [1:0] OSC_MODE_HIGH_SPEED_CRYSTAL = 2'h2;
    localparam logic [1:0] OSC_MODE_RC                 = 2'h3;

    typedef enum logic [2:0] {
        PORST_POR,
        PORST_BROWN_OUT,
        PORST_PWRUP,
        PORST_OSC_START,
        PORST_RUN,
        PORST_SLEEP
    } porst_state_e;
endpackage

/* porst_rc_tick.sv */
// Internal RC oscillator stand-in: divides the system clock into a one-cycle tick.
// Assumes clk is the free-running 250 MHz system clock.
`timescale 1ns/100ps
module porst_rc_tick
    import porst_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      tick
);
    logic [RC_DIV_W-1:0] div_ff;
    logic [RC_DIV_W-1:0] nxt_div;

    always_comb begin
        nxt_div = div_ff + 8'h01;
        if (clear || div_ff == RC_DIV_W'(RC_TICK_CYCLES - 1)) begin
            nxt_div = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign tick = !clear && (div_ff == RC_DIV_W'(RC_TICK_CYCLES - 1));
endmodule

/* porst_sequencer.sv */
// Power-on reset sequencer: holds the core in reset through power-on, brown-out,
// the power-up timer and the oscillator start-up count.
// Assumes detector inputs and the oscillator input pin are synchronous to clk.
`timescale 1ns/100ps
module porst_sequencer
    import porst_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       supply_ok,
    input  wire logic       below_brown_out_threshold,
    input  wire logic       other_reset_req,
    input  wire logic       sleep_req,
    input  wire logic       wake_req,
    input  wire logic       power_up_timer_disable,
    input  wire logic       brown_out_enable,
    input  wire logic [1:0] osc_mode,
    input  wire logic       oscillator_input_pin,
    output logic            core_reset_n,
    output logic            core_sleeping,
    output logic            brown_out_flag
);
    porst_state_e         state_ff;
    porst_state_e         nxt_state;
    logic [PWRUP_CNT_W-1:0]     pwrup_cnt_ff;
    logic [PWRUP_CNT_W-1:0]     nxt_pwrup_cnt;
    logic [OSC_CNT_W-1:0]       osc_cnt_ff;
    logic [OSC_CNT_W-1:0]       nxt_osc_cnt;
    logic [BROWN_OUT_CNT_W-1:0] bo_cnt_ff;
    logic [BROWN_OUT_CNT_W-1:0] nxt_bo_cnt;
    logic                 osc_pin_ff;
    logic                 core_reset_n_ff;
    logic                 nxt_core_reset_n;
    logic                 bo_flag_ff;
    logic                 nxt_bo_flag;
    logic                 rc_tick;
    logic                 rc_clear;
    logic                 osc_rise;
    logic                 crystal_mode;
    logic                 brown_out_hit;
    logic                 start_after_pwrup;

    // The power-up timer counts RC ticks, never system clock edges directly.
    porst_rc_tick u_rc_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .clear (rc_clear),
        .tick  (rc_tick)
    );

    assign rc_clear     = (state_ff != PORST_PWRUP);
    assign osc_rise     = oscillator_input_pin && !osc_pin_ff;
    assign crystal_mode = (osc_mode != OSC_MODE_RC);
    // A slow rise that lingers below the threshold stays a power-on reset, so its start-up count is kept.
    assign brown_out_hit = brown_out_enable && (state_ff != PORST_POR) &&
                           (bo_cnt_ff == BROWN_OUT_CNT_W'(BROWN_OUT_MIN_CYCLES));

    // Start-up count follows the hold only in crystal modes and only after power-on.
    // The brown-out flag stays set from the dip until release, so it marks a brown-out hold.
    assign start_after_pwrup = crystal_mode && !bo_flag_ff;

    // Low-supply qualification counter saturates once the dip is long enough.
    always_comb begin
        nxt_bo_cnt = '0;
        if (below_brown_out_threshold && brown_out_enable) begin
            nxt_bo_cnt = bo_cnt_ff;
            if (bo_cnt_ff != BROWN_OUT_CNT_W'(BROWN_OUT_MIN_CYCLES)) begin
                nxt_bo_cnt = bo_cnt_ff + 16'h0001;
            end
        end
    end

    always_comb begin
        nxt_state     = state_ff;
        nxt_pwrup_cnt = pwrup_cnt_ff;
        nxt_osc_cnt   = osc_cnt_ff;
        nxt_bo_flag   = bo_flag_ff;
        case (state_ff)
            PORST_POR: begin
                // Only a rising supply leaves this state; a falling supply elsewhere is brown-out's job.
                if (supply_ok && !(brown_out_enable && below_brown_out_threshold)) begin
                    nxt_pwrup_cnt = '0;
                    nxt_osc_cnt   = '0;
                    if (!power_up_timer_disable) begin
                        nxt_state = PORST_PWRUP;
                    end else if (start_after_pwrup) begin
                        nxt_state = PORST_OSC_START;
                    end else begin
                        nxt_state = PORST_RUN;
                    end
                end
            end
            PORST_BROWN_OUT: begin
                if (!below_brown_out_threshold) begin
                    nxt_pwrup_cnt = '0;
                    nxt_osc_cnt   = '0;
                    if (!power_up_timer_disable) begin
                        nxt_state = PORST_PWRUP;
                    end else if (start_after_pwrup) begin
                        nxt_state = PORST_OSC_START;
                    end else begin
                        nxt_state = PORST_RUN;
                    end
                end
            end
            PORST_PWRUP: begin
                if (rc_tick) begin
                    nxt_pwrup_cnt = pwrup_cnt_ff + 17'h00001;
                end
                if (rc_tick && pwrup_cnt_ff == PWRUP_CNT_W'(PWRUP_HOLD_TICKS - 1)) begin
                    nxt_state = start_after_pwrup ? PORST_OSC_START : PORST_RUN;
                end
            end
            PORST_OSC_START: begin
                if (osc_rise) begin
                    nxt_osc_cnt = osc_cnt_ff + 11'h001;
                end
                if (osc_rise && osc_cnt_ff == OSC_CNT_W'(OSC_STARTUP_CYCLES - 1)) begin
                    nxt_state = PORST_RUN;
                end
            end
            PORST_RUN: begin
                if (sleep_req) begin
                    nxt_state = PORST_SLEEP;
                end else if (other_reset_req) begin
                    // Other sources hold reset but skip the power-up timer and start-up count.
                    nxt_state = PORST_RUN;
                end
            end
            PORST_SLEEP: begin
                if (wake_req) begin
                    nxt_osc_cnt = '0;
                    nxt_state   = crystal_mode ? PORST_OSC_START : PORST_RUN;
                end
            end
            default: begin
                nxt_state = PORST_POR;
            end
        endcase
        // A qualified dip overrides everything outside the power-on state, including a running power-up timer.
        if (brown_out_hit) begin
            nxt_state     = PORST_BROWN_OUT;
            nxt_pwrup_cnt = '0;
            nxt_bo_flag   = 1'b1;
        end else if (nxt_state == PORST_RUN && state_ff != PORST_RUN) begin
            nxt_bo_flag = 1'b0;
        end
        nxt_core_reset_n = (nxt_state == PORST_RUN || nxt_state == PORST_SLEEP) &&
                           !(nxt_state == PORST_RUN && other_reset_req);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff        <= PORST_POR;
            pwrup_cnt_ff    <= '0;
            osc_cnt_ff      <= '0;
            bo_cnt_ff       <= '0;
            osc_pin_ff      <= 1'b0;
            core_reset_n_ff <= 1'b0;
            bo_flag_ff      <= 1'b0;
        end else begin
            state_ff        <= nxt_state;
            pwrup_cnt_ff    <= nxt_pwrup_cnt;
            osc_cnt_ff      <= nxt_osc_cnt;
            bo_cnt_ff       <= nxt_bo_cnt;
            osc_pin_ff      <= oscillator_input_pin;
            core_reset_n_ff <= nxt_core_reset_n;
            bo_flag_ff      <= nxt_bo_flag;
        end
    end

    assign core_reset_n   = core_reset_n_ff;
    assign core_sleeping  = (state_ff == PORST_SLEEP);
    assign brown_out_flag = bo_flag_ff;

    // Assertions.
    a_reset_in_por: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_POR |-> !core_reset_n)
        else $error("core released while in power-on state");
    a_no_early_release: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_PWRUP && !brown_out_hit &&
        !(rc_tick && pwrup_cnt_ff == PWRUP_CNT_W'(PWRUP_HOLD_TICKS - 1))
        |=> state_ff == PORST_PWRUP && !core_reset_n)
        else $error("core released during power-up hold");
    a_pwrup_hold_reset: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_PWRUP |-> !core_reset_n)
        else $error("core out of reset during power-up timer");
    a_pwrup_full_count: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == PORST_PWRUP && $past(state_ff) == PORST_PWRUP)
        ##1 (state_ff == PORST_OSC_START || state_ff == PORST_RUN)
        |-> $past(pwrup_cnt_ff) == PWRUP_CNT_W'(PWRUP_HOLD_TICKS - 1))
        else $error("power-up hold ended early");
    a_osc_full_count: assert property (@(posedge clk) disable iff (!rst_n)
        $past(state_ff) == PORST_OSC_START && state_ff == PORST_RUN
        |-> $past(osc_cnt_ff) == OSC_CNT_W'(OSC_STARTUP_CYCLES - 1) && $past(osc_rise))
        else $error("start-up count ended early");
    a_rc_no_osc: assert property (@(posedge clk) disable iff (!rst_n)
        osc_mode == OSC_MODE_RC && state_ff != PORST_OSC_START |=> state_ff != PORST_OSC_START)
        else $error("start-up count entered in RC mode");
    a_bo_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        !brown_out_enable && state_ff == PORST_RUN && !sleep_req |=> state_ff == PORST_RUN)
        else $error("brown-out taken while disabled");
    a_bo_short_dip: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_RUN && bo_cnt_ff < BROWN_OUT_CNT_W'(BROWN_OUT_MIN_CYCLES) && !sleep_req
        |=> state_ff == PORST_RUN)
        else $error("brown-out on short dip");
    a_bo_restart: assert property (@(posedge clk) disable iff (!rst_n)
        brown_out_hit |=> state_ff == PORST_BROWN_OUT && pwrup_cnt_ff == '0 && !core_reset_n)
        else $error("brown-out did not restart hold");
    a_bo_skip_start: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_PWRUP && bo_flag_ff |=> state_ff != PORST_OSC_START)
        else $error("start-up count run after brown-out");
    a_timer_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_BROWN_OUT && !below_brown_out_threshold && power_up_timer_disable && !brown_out_hit
        |=> state_ff != PORST_PWRUP)
        else $error("power-up timer ran while disabled");

    c_power_up_run: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(core_reset_n));
    c_brown_out: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_PWRUP ##1 state_ff == PORST_BROWN_OUT);
    c_wake: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff == PORST_SLEEP ##1 state_ff == PORST_OSC_START);
endmodule

/* test_porst_sequencer.sv */
// Self-checking bench for the power-on reset sequencer with its supply and crystal partner.
// Assumes the full power-up hold is too long to run, so only its start is observed.
`timescale 1ns/100ps
module test_porst_sequencer;
    import porst_pkg::*;
    typedef struct {logic v; int lo; int hi; int edges;} porst_note_s;
    logic        clk, rst_n, osc_run, sleep_req, wake_req, other_reset_req, armed, up;
    logic        power_up_timer_disable, brown_out_enable, supply_ok, below, pin;
    logic        core_reset_n, core_sleeping, brown_out_flag;
    logic [1:0]  osc_mode;
    logic [15:0] vdd_mv;
    int          cyc, fail_count, n_tests, pin_edges;
    porst_note_s notes[$];
    logic [1:0]  modes [3] = '{OSC_MODE_LOW_POWER_CRYSTAL, OSC_MODE_MEDIUM_CRYSTAL, OSC_MODE_HIGH_SPEED_CRYSTAL};

    porst_sequencer u_dut (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
        .below_brown_out_threshold(below), .other_reset_req(other_reset_req), .sleep_req(sleep_req),
        .wake_req(wake_req), .power_up_timer_disable(power_up_timer_disable),
        .brown_out_enable(brown_out_enable), .osc_mode(osc_mode), .oscillator_input_pin(pin),
        .core_reset_n(core_reset_n), .core_sleeping(core_sleeping), .brown_out_flag(brown_out_flag));
    porst_partner u_partner (.clk(clk), .vdd_mv(vdd_mv), .osc_run(osc_run), .supply_ok(supply_ok),
        .below_brown_out_threshold(below), .oscillator_input_pin(pin), .pin_edges(pin_edges));

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic close_out();
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Notes a reset edge with the cycle window and pin edge count it must show up with.
    task automatic expect_edge(input logic v, input int lo, input int hi, input int edges);
        notes.push_back('{v, cyc + lo, cyc + hi, edges});
        up = v;
    endtask

    // Every change of the core reset must match the oldest note; an unnoted change is a fault.
    always @(core_reset_n) begin
        if (armed) begin
            porst_note_s n;
            n_tests++;
            if (notes.size() == 0) begin
                fail_count++;
                $display("BAD core_reset_n expected no change seen %b at %0d", core_reset_n, cyc);
            end else begin
                n = notes.pop_front();
                if (core_reset_n !== n.v || cyc < n.lo || cyc > n.hi || (n.edges >= 0 && pin_edges != n.edges)) begin
                    fail_count++;
                    $display("BAD core_reset_n expected %b in %0d..%0d edges %0d seen %b at %0d edges %0d",
                             n.v, n.lo, n.hi, n.edges, core_reset_n, cyc, pin_edges);
                end
            end
        end
    end

    task automatic wait_drain(input int limit);
        for (int i = 0; i < limit && notes.size() != 0; i++) @(posedge clk);
        if (notes.size() != 0) begin
            fail_count++;
            $display("BAD pending notes expected 0 seen %0d", notes.size());
            close_out();
        end
    endtask

    task automatic power_up(input logic dis, input logic [1:0] mode);
        if (up) expect_edge(1'b0, 0, 2, -1);
        osc_run <= 1'b0;
        vdd_mv <= 16'(500 + $urandom_range(0, 900));
        rst_n <= 1'b0;
        power_up_timer_disable <= dis;
        osc_mode <= mode;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        armed = 1'b1;
        repeat (10) @(posedge clk);
        chk("core_reset_n low supply", 1'b0, core_reset_n);
        vdd_mv <= 16'(4100 + $urandom_range(0, 1400));
        osc_run <= (mode != OSC_MODE_RC);
    endtask

    initial begin
        clk = 1'b0; rst_n = 1'b0; vdd_mv = 16'h0; osc_run = 1'b0; armed = 1'b0; up = 1'b0;
        sleep_req = 1'b0; wake_req = 1'b0; other_reset_req = 1'b0;
        power_up_timer_disable = 1'b1; brown_out_enable = 1'b0; osc_mode = OSC_MODE_RC;
        cyc = 0; fail_count = 0; n_tests = 0;
        void'($urandom(32'h7c0cbfd3));
        brown_out_enable <= 1'b1;
        power_up(1'b0, OSC_MODE_RC);
        repeat (2000) @(posedge clk);
        chk("core_reset_n timer hold", 1'b0, core_reset_n);
        foreach (modes[i]) begin
            power_up(1'b1, modes[i]);
            expect_edge(1'b1, 8 * 1024 - 8, 8 * 1024 + 16, OSC_STARTUP_CYCLES);
            wait_drain(9000);
        end
        // Sleep keeps the core out of reset; wake in a crystal mode reruns the start-up count.
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        @(posedge clk);
        chk("core_sleeping in sleep", 1'b1, core_sleeping);
        wake_req <= 1'b1;
        expect_edge(1'b0, 0, 3, -1);
        expect_edge(1'b1, 8 * 1024 - 8, 8 * 1024 + 16, -1);
        @(posedge clk);
        wake_req <= 1'b0;
        wait_drain(9000);
        chk("core_sleeping after wake", 1'b0, core_sleeping);
        power_up(1'b1, OSC_MODE_RC);
        expect_edge(1'b1, 1, 10, -1);
        wait_drain(50);
        // The timer is enabled here, so a release within a few cycles shows it was not started.
        other_reset_req <= 1'b1;
        power_up_timer_disable <= 1'b0;
        expect_edge(1'b0, 0, 3, -1);
        repeat ($urandom_range(2, 40)) @(posedge clk);
        other_reset_req <= 1'b0;
        expect_edge(1'b1, 0, 3, -1);
        wait_drain(50);
        power_up_timer_disable <= 1'b1;
        vdd_mv <= 16'(3000 + $urandom_range(0, 900));
        repeat ($urandom_range(100, 8000)) @(posedge clk);
        vdd_mv <= 16'h1388;
        repeat (10) @(posedge clk);
        vdd_mv <= 16'(3000 + $urandom_range(0, 900));
        expect_edge(1'b0, BROWN_OUT_MIN_CYCLES, BROWN_OUT_MIN_CYCLES + 8, -1);
        wait_drain(25100);
        chk("brown_out_flag set", 1'b1, brown_out_flag);
        vdd_mv <= 16'h1388;
        expect_edge(1'b1, 1, 10, -1);
        wait_drain(50);
        @(posedge clk);
        chk("brown_out_flag cleared", 1'b0, brown_out_flag);
        brown_out_enable <= 1'b0;
        vdd_mv <= 16'h0320;
        repeat (25100) @(posedge clk);
        chk("brown_out_flag disabled", 1'b0, brown_out_flag);
        chk("core_reset_n falling supply", 1'b1, core_reset_n);
        close_out();
    end
endmodule
